// file: core/process_event_alarm_logic.sv
`timescale 1ns/100ps
// Behaviour
// - Hold suppresses at power-up and STOP-to-RUN
// - Re-hold suppresses after each setpoint change
// - Code 1 hold only, code 2 adds re-hold
// - Rate limiter or remote disables re-hold only
// - Re-hold masks setpoint-change deviation events
// - Interlock latches the event once asserted
// - Differential gap gives hysteresis around threshold
// - Gap ranges span or 110 %, default 2
// - Delay 0.0 to 600.0 s, default 0
// - Output after delay only if still on
// - Force-on asserts output during input error
// - Type code selects the comparison kind
// - No hold for setpoint-value types
// - Deviation types compare measured minus setpoint
// - Process types compare measured value itself
// - Hold code 0 disables all suppression
module process_event_alarm_logic (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire event_alarm_pkg::event_cfg_s cfg_i,
  input wire event_alarm_pkg::process_in_s proc_i,
  input wire logic interlock_clear_i,
  output logic event_out_o,
  output logic event_cond_o,
  output logic hold_active_o,
  output logic delay_running_o,
  output logic cfg_error_o
);
  import event_alarm_pkg::*;

  // Whole state of the event channel
  typedef struct packed {
    logic cond;           // Qualified condition with hysteresis
    logic hold;           // Suppression in force
    logic latched;        // Interlock latch
    logic run_d;          // Previous run level
    logic signed [15:0] setp_d; // Previous setpoint
    logic setp_valid;     // Previous setpoint captured
    logic [12:0] dly_cnt; // Elapsed tenths of a second
    logic qualified;      // Delay expired with condition still on
    logic out;            // Event output register
  } chan_state_s;

  chan_state_s st_r;
  chan_state_s st_nxt;
  logic tick;

  // 0.1 s time base
  tick_timer #(
    .PERIOD(TICK_CYCLES),
    .W(TICK_W)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .tick_o(tick)
  );

  logic signed [17:0] meas;  // Measured value, widened
  logic signed [17:0] setp;  // Setpoint, widened
  logic signed [17:0] dev;   // Measured minus setpoint
  logic signed [17:0] thr;   // Event set value
  logic signed [17:0] gap;   // Differential gap
  logic signed [17:0] sel;   // Value under comparison
  logic is_high;             // High-side comparison
  logic is_low;              // Low-side comparison
  logic is_band;             // Band comparison
  logic hold_allowed;        // Type admits hold
  logic type_ok;             // Comparison is defined
  logic on_set;              // Threshold reached
  logic off_set;             // Back beyond the gap
  logic raw;                 // Condition with hysteresis
  logic setp_change;         // Setpoint changed this cycle
  logic rehold_ok;           // Re-hold may be applied
  logic start_hold;          // Reason to begin suppression
  logic [12:0] dly_lim;      // Clamped delay setting

  // Select compared value and direction from the type code
  always_comb
  begin
    meas = 18'(proc_i.measured_value);
    setp = 18'(proc_i.control_setpoint);
    dev = meas - setp;
    thr = 18'(cfg_i.event_setpoint);
    gap = 18'(cfg_i.diff_gap);
    sel = meas;
    is_high = 1'b0;
    is_low = 1'b0;
    is_band = 1'b0;
    hold_allowed = 1'b1;
    type_ok = 1'b1;
    unique case (cfg_i.type_code)
      TYPE_DEV_HI:
      begin
        sel = dev;
        is_high = 1'b1;
      end
      TYPE_DEV_LO:
      begin
        sel = dev;
        is_low = 1'b1;
      end
      TYPE_DEV_HILO:
      begin
        sel = dev;
        is_high = 1'b1;
        is_low = 1'b1;
      end
      TYPE_BAND:
      begin
        sel = dev;
        is_band = 1'b1;
      end
      TYPE_PROC_HI:
        is_high = 1'b1;
      TYPE_PROC_LO:
        is_low = 1'b1;
      TYPE_SETP_HI:
      begin
        sel = setp;
        is_high = 1'b1;
        hold_allowed = 1'b0;
      end
      TYPE_SETP_LO:
      begin
        sel = setp;
        is_low = 1'b1;
        hold_allowed = 1'b0;
      end
      TYPE_HEAT_HI:
      begin
        sel = 18'(proc_i.heat_side_output_level);
        is_high = 1'b1;
      end
      TYPE_HEAT_LO:
      begin
        sel = 18'(proc_i.heat_side_output_level);
        is_low = 1'b1;
      end
      TYPE_COOL_HI:
      begin
        sel = 18'(proc_i.cool_side_output_level);
        is_high = 1'b1;
      end
      TYPE_COOL_LO:
      begin
        sel = 18'(proc_i.cool_side_output_level);
        is_low = 1'b1;
      end
      default:
        type_ok = 1'b0;                             // None, 9, 14, 15
    endcase
  end

  // Threshold compare with hysteresis; hi-lo/band use deviation magnitude
  always_comb
  begin
    on_set = 1'b0;
    off_set = 1'b1;
    if (is_band)
    begin
      // Band: event while |dev| reaches or exceeds the set value
      on_set = (sel >= thr) || (sel <= -thr);
      off_set = (sel < thr - gap) && (sel > -thr + gap);
    end
    else if (is_high && is_low)
    begin
      on_set = (sel >= thr) || (sel <= -thr);
      off_set = (sel < thr - gap) && (sel > -thr + gap);
    end
    else if (is_high)
    begin
      on_set = sel >= thr;
      off_set = sel < thr - gap;
    end
    else if (is_low)
    begin
      // Deviation low uses a positive set value on the low side
      if (cfg_i.type_code == TYPE_DEV_LO)
      begin
        on_set = sel <= -thr;
        off_set = sel > -thr + gap;
      end
      else
      begin
        on_set = sel <= thr;
        off_set = sel > thr + gap;
      end
    end
    // Hold current state inside the gap window
    if (!type_ok)
      raw = 1'b0;
    else if (st_r.cond)
      raw = !off_set;
    else
      raw = on_set;
  end

  // Suppression causes and delay limit
  always_comb
  begin
    setp_change = st_r.setp_valid
      && (proc_i.control_setpoint != st_r.setp_d);
    rehold_ok = (cfg_i.hold_mode == HOLD_REHOLD)
      && !proc_i.rate_limiter_on && !proc_i.remote_mode;
    start_hold = 1'b0;
    if (hold_allowed && cfg_i.hold_mode != HOLD_OFF)
    begin
      if (!st_r.setp_valid || (proc_i.run && !st_r.run_d))
        start_hold = 1'b1;
      if (rehold_ok && setp_change)
        start_hold = 1'b1;
    end
    dly_lim = (cfg_i.delay_tenths > DELAY_MAX) ? DELAY_MAX
      : cfg_i.delay_tenths;
  end

  // Next state of the channel
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.run_d = proc_i.run;
    st_nxt.setp_d = proc_i.control_setpoint;
    st_nxt.setp_valid = 1'b1;
    st_nxt.cond = raw;
    // Suppression starts on a cause and ends in the non-event range
    if (start_hold)
      st_nxt.hold = 1'b1;
    else if (!raw || !hold_allowed || cfg_i.hold_mode == HOLD_OFF)
      st_nxt.hold = 1'b0;
    // Delay: restart on drop, count ticks while condition stands
    if (!raw || st_r.hold)
    begin
      st_nxt.dly_cnt = '0;
      st_nxt.qualified = 1'b0;
    end
    else if (st_r.dly_cnt >= dly_lim)
      st_nxt.qualified = 1'b1;
    else if (tick)
      st_nxt.dly_cnt = st_r.dly_cnt + 13'h0001;
    // Interlock latch, cleared by reset, the clear input or interlock disable
    if (interlock_clear_i || !cfg_i.interlock_en)
      st_nxt.latched = 1'b0;
    else if (st_r.out)
      st_nxt.latched = 1'b1;
    // Output combination
    if (cfg_i.force_on_en && proc_i.input_error)
      st_nxt.out = 1'b1;
    else
      st_nxt.out = (st_r.qualified && raw && !st_r.hold)
        || st_nxt.latched;
  end

  // State register
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Outputs from state
  assign event_out_o = st_r.out;
  assign event_cond_o = st_r.cond;
  assign hold_active_o = st_r.hold;
  assign delay_running_o = st_r.cond && !st_r.qualified && !st_r.hold;
  // Flags code 9 and undefined codes, which should never be programmed
  assign cfg_error_o = (cfg_i.type_code == TYPE_UNUSED)
    || (cfg_i.type_code > TYPE_COOL_LO);

endmodule : process_event_alarm_logic

// file: core/tick_timer.sv
`timescale 1ns/100ps
// Free-running divider giving one-cycle pulses every PERIOD cycles
module tick_timer #(
  parameter int PERIOD = 10,
  parameter int W = 24
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  output logic tick_o
);
  import event_alarm_pkg::*;

  // Whole state of the divider
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tick_state_s;

  tick_state_s st_r;
  tick_state_s st_nxt;

  // Count up and pulse on wrap
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == W'(PERIOD - 1))
    begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  // State register
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick_o = st_r.tick;

endmodule : tick_timer

// file: inc/event_alarm_pkg.sv
package event_alarm_pkg;

  // Value width for measured, set and output values (signed)
  localparam int VAL_W = 16;

  // Event type codes
  localparam logic [3:0] TYPE_NONE = 4'h0;
  localparam logic [3:0] TYPE_DEV_HI = 4'h1;
  localparam logic [3:0] TYPE_DEV_LO = 4'h2;
  localparam logic [3:0] TYPE_DEV_HILO = 4'h3;
  localparam logic [3:0] TYPE_BAND = 4'h4;
  localparam logic [3:0] TYPE_PROC_HI = 4'h5;
  localparam logic [3:0] TYPE_PROC_LO = 4'h6;
  localparam logic [3:0] TYPE_SETP_HI = 4'h7;
  localparam logic [3:0] TYPE_SETP_LO = 4'h8;
  localparam logic [3:0] TYPE_UNUSED = 4'h9;
  localparam logic [3:0] TYPE_HEAT_HI = 4'hA;
  localparam logic [3:0] TYPE_HEAT_LO = 4'hB;
  localparam logic [3:0] TYPE_COOL_HI = 4'hC;
  localparam logic [3:0] TYPE_COOL_LO = 4'hD;

  // Hold mode codes
  localparam logic [1:0] HOLD_OFF = 2'h0;
  localparam logic [1:0] HOLD_ONLY = 2'h1;
  localparam logic [1:0] HOLD_REHOLD = 2'h2;

  // Differential gap reset value
  localparam logic [15:0] GAP_RESET = 16'h0002;
  // Delay setting limit in 0.1 s units (600.0 s) and reset value
  localparam logic [12:0] DELAY_MAX = 13'h1770;
  localparam logic [12:0] DELAY_RESET = 13'h0000;

  // Timing: delay tick 0.1 s at a 100 MHz clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 100_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 24;

  // Configuration of one event channel
  typedef struct packed {
    logic [3:0] type_code;
    logic [1:0] hold_mode;
    logic interlock_en;
    logic force_on_en;
    logic [15:0] diff_gap;
    logic [12:0] delay_tenths;
    logic signed [15:0] event_setpoint;
  } event_cfg_s;

  // Process inputs sampled every clock
  typedef struct packed {
    logic signed [15:0] measured_value;
    logic signed [15:0] control_setpoint;
    logic signed [15:0] heat_side_output_level;
    logic signed [15:0] cool_side_output_level;
    logic run;
    logic rate_limiter_on;
    logic remote_mode;
    logic input_error;
  } process_in_s;

endpackage : event_alarm_pkg

// file: tb/proc_source.sv
`timescale 1ns/100ps
// Far-side model: the whole process-input path feeding the event logic
module proc_source (
  input wire logic sys_clk_i,
  output event_alarm_pkg::process_in_s proc_o
);
  import event_alarm_pkg::*;
  // Values change one step after an edge and then stand as levels
  task automatic put(input process_in_s v);
    @(posedge sys_clk_i);
    #1 proc_o = v;
  endtask : put
  initial proc_o = '0;
endmodule : proc_source

// file: tb/process_event_alarm_props.sv
`timescale 1ns/100ps
// Port-level checks on the event qualifier
module process_event_alarm_props (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire event_alarm_pkg::event_cfg_s cfg_i,
  input wire event_alarm_pkg::process_in_s proc_i,
  input wire logic interlock_clear_i,
  input wire logic event_out_o,
  input wire logic event_cond_o,
  input wire logic hold_active_o,
  input wire logic delay_running_o,
  input wire logic cfg_error_o
);
  import event_alarm_pkg::*;
  // No latch and no forcing can hold the output up
  logic plain;
  // Plain process-high setup with the value in the event area
  logic proc_hi_on;
  assign plain = !cfg_i.interlock_en && !cfg_i.force_on_en;
  assign proc_hi_on = plain && cfg_i.type_code == TYPE_PROC_HI
    && cfg_i.hold_mode == HOLD_OFF && cfg_i.delay_tenths == '0
    && !proc_i.input_error && !hold_active_o
    && proc_i.measured_value >= cfg_i.event_setpoint;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_cfg_code_flag: assert property (
    cfg_error_o == (cfg_i.type_code == TYPE_UNUSED
      || cfg_i.type_code > TYPE_COOL_LO)) else $error("bad cfg error");
  a_type_none_quiet: assert property (
    cfg_i.type_code == TYPE_NONE [*2] |-> !event_cond_o)
    else $error("type none raised condition");
  a_proc_high_out: assert property (
    proc_hi_on [*5] |-> event_out_o) else $error("process high missed");
  a_force_on_out: assert property (
    cfg_i.force_on_en && proc_i.input_error |=> event_out_o)
    else $error("force-on missed");
  a_latch_keeps_out: assert property (
    event_out_o && cfg_i.interlock_en && !interlock_clear_i |=> event_out_o)
    else $error("latched event dropped");
  a_drop_clears_out: assert property (
    (plain && !event_cond_o) [*3] |-> !event_out_o)
    else $error("output without condition");
  a_delay_run_cond: assert property (
    delay_running_o && plain |-> event_cond_o && !event_out_o)
    else $error("delay flag wrong");
  a_delay_holds_out: assert property (
    $rose(event_cond_o) && plain && cfg_i.delay_tenths > 13'h0001
    |=> !event_out_o [*8]) else $error("delay not applied");
  a_reset_clears_all: assert property (
    $rose(reset_n_i) |-> !event_out_o && !event_cond_o)
    else $error("state left after reset");
endmodule : process_event_alarm_props

bind process_event_alarm_logic process_event_alarm_props u_props (
  .sys_clk_i, .reset_n_i, .cfg_i, .proc_i, .interlock_clear_i, .event_out_o,
  .event_cond_o, .hold_active_o, .delay_running_o, .cfg_error_o);

// file: tb/tb_process_event_alarm_logic.sv
`timescale 1ns/100ps
// Self-checking bench for the event qualifier
module tb_process_event_alarm_logic;
  import event_alarm_pkg::*;
  localparam int LIMIT = 20000; // Cycle ceiling for the run
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clr = 1'b0;
  event_cfg_s cfg;
  process_in_s stim; // Values the far side will present
  process_in_s proc;
  logic ev_out, ev_cond, hold, dly_run, cfg_err;
  int cycles = 0;
  int fails = 0;
  int cmp_count = 0;
  proc_source src (.sys_clk_i(sys_clk_i), .proc_o(proc));
  process_event_alarm_logic dut (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .cfg_i(cfg), .proc_i(proc),
    .interlock_clear_i(clr), .event_out_o(ev_out), .event_cond_o(ev_cond),
    .hold_active_o(hold), .delay_running_o(dly_run), .cfg_error_o(cfg_err));
  always #5 sys_clk_i = ~sys_clk_i;
  // Cuts a hung run short
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic e, input logic s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, s);
    end
  endtask : chk
  // Hand values to the far side, then let n edges pass
  task automatic go(input int n);
    src.put(stim);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : go
  task automatic mv(input int v);
    stim.measured_value = 16'(v);
    go(6);
  endtask : mv
  task automatic rst();
    reset_n_i = 1'b0;
    go(6);
    reset_n_i = 1'b1;
  endtask : rst
  task automatic t_basic();
    mv(50);
    chk("out low", 1'b0, ev_out);
    mv(100);
    chk("out at thr", 1'b1, ev_out);
    mv(98);
    chk("out in gap", 1'b1, ev_out);
    mv(97);
    chk("out under gap", 1'b0, ev_out);
    $display("t_basic done");
  endtask : t_basic
  task automatic t_types();
    logic e;
    stim.control_setpoint = 16'sh00C8;
    stim.heat_side_output_level = 16'sh00C8;
    stim.cool_side_output_level = 16'sh00C8;
    for (int c = 0; c < 16; c++)
      if (c != 9) // Unused code is never programmed
      begin
        cfg.type_code = 4'(c);
        e = (c > 4 && c < 9) ? c[0] : ((c > 9 && c < 14) ? !c[0] : 1'b0);
        mv(200);
        chk("type out", e, ev_out);
        chk("cfg error", c > 13, cfg_err);
      end
    $display("t_types done");
  endtask : t_types
  task automatic t_power(input logic [1:0] h, input logic [3:0] t,
    input logic e);
    cfg.hold_mode = h;
    cfg.type_code = t;
    stim.measured_value = 16'sh0096;
    stim.control_setpoint = 16'sh0096;
    rst();
    go(6);
    chk("power-up out", e, ev_out);
  endtask : t_power
  task automatic t_hold();
    t_power(HOLD_ONLY, TYPE_PROC_HI, 1'b0);
    chk("hold flag", 1'b1, hold);
    mv(50);
    mv(150);
    chk("out after clear", 1'b1, ev_out);
    stim.run = 1'b0;
    mv(50);
    stim.run = 1'b1;
    mv(150);
    chk("out after run", 1'b0, ev_out);
    mv(50);
    mv(150);
    stim.control_setpoint = 16'sh0005;
    go(6);
    chk("setp change hold only", 1'b1, ev_out);
    t_power(HOLD_OFF, TYPE_PROC_HI, 1'b1);
    t_power(HOLD_ONLY, TYPE_SETP_HI, 1'b1);
    $display("t_hold done");
  endtask : t_hold
  task automatic t_setp(input logic [1:0] h, input logic rl, input logic rm,
    input logic e);
    cfg.type_code = TYPE_DEV_HI;
    cfg.event_setpoint = 16'sh000A;
    cfg.hold_mode = h;
    stim.rate_limiter_on = rl;
    stim.remote_mode = rm;
    stim.control_setpoint = 16'sh0064;
    mv(105);
    stim.control_setpoint = 16'sh005A;
    go(6);
    chk("setp change out", e, ev_out);
    mv(95);
    mv(105);
    chk("deviation out", 1'b1, ev_out);
    $display("t_setp done");
  endtask : t_setp
  task automatic t_misc();
    cfg.type_code = TYPE_PROC_HI;
    cfg.event_setpoint = 16'sh0064;
    cfg.interlock_en = 1'b1;
    mv(150);
    mv(50);
    chk("latched out", 1'b1, ev_out);
    clr = 1'b1;
    go(2);
    clr = 1'b0;
    go(6);
    chk("cleared out", 1'b0, ev_out);
    cfg.interlock_en = 1'b0;
    cfg.type_code = TYPE_NONE;
    cfg.force_on_en = 1'b1;
    stim.input_error = 1'b1;
    go(6);
    chk("forced out", 1'b1, ev_out);
    cfg.force_on_en = 1'b0;
    go(6);
    chk("unforced out", 1'b0, ev_out);
    stim.input_error = 1'b0;
    $display("t_misc done");
  endtask : t_misc
  task automatic t_delay();
    cfg.type_code = TYPE_PROC_HI;
    cfg.delay_tenths = 13'h0005;
    mv(50);
    stim.measured_value = 16'sh0096;
    go(1000);
    chk("delayed out", 1'b0, ev_out);
    chk("delay running", 1'b1, dly_run);
    cfg.delay_tenths = DELAY_MAX;
    go(6);
    chk("max delay out", 1'b0, ev_out);
    mv(50);
    chk("delay restart", 1'b0, dly_run);
    $display("t_delay done");
  endtask : t_delay
  initial
  begin
    cfg = '0;
    cfg.diff_gap = GAP_RESET;
    cfg.event_setpoint = 16'sh0064;
    cfg.type_code = TYPE_PROC_HI;
    stim = '0;
    stim.run = 1'b1;
    rst();
    t_basic();
    t_types();
    t_hold();
    t_setp(HOLD_REHOLD, 1'b0, 1'b0, 1'b0);
    t_setp(HOLD_REHOLD, 1'b1, 1'b0, 1'b1);
    t_setp(HOLD_REHOLD, 1'b0, 1'b1, 1'b1);
    t_setp(HOLD_ONLY, 1'b0, 1'b0, 1'b1);
    t_setp(HOLD_OFF, 1'b0, 1'b0, 1'b1);
    t_misc();
    t_delay();
    close_out();
  end
endmodule : tb_process_event_alarm_logic
